// *** ubx_top.sv ***
// Nine-bit multidrop interrupt and queue extension logic, Wishbone slave
`timescale 1ns/1ps
module ubx_top (
  // Clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  // Wishbone classic slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output      logic [31:0] WB_DAT_O,
  output      logic        WB_ACK_O,
  // Receiver side
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_NINTH,
  input  wire logic [7:0]  RX_FILL,
  // Configuration and threshold hit out to the serial core
  output      logic        MULTIDROP_ENABLE,
  output      logic        DEEP_QUEUE_ENABLE,
  output      logic        PORT_SWAP_BYPASS,
  output      logic [7:0]  QUEUE_DEPTH,
  output      logic [7:0]  RX_THRESHOLD,
  output      logic        RX_TRIGGER_HIT,
  // Interrupts
  output      logic        NINE_BIT_IRQ,
  output      logic        IRQ
);
  import ubx_pkg::*;

  ubx_bus_t   bus_state;       // Slave handshake state
  logic [7:0] md_config;       // Multidrop configuration
  logic [7:0] slave_addr;      // Own address
  logic [7:0] slave_mask;      // Compare mask
  logic [7:0] bcast_addr;      // Broadcast address
  logic [1:0] nb_ctrl;         // Type select and enable
  logic       nb_flag;         // Sticky nine-bit status
  logic [7:0] ext_ctrl;        // Extension control
  logic [1:0] queue_trig;      // Trigger code of queue control
  logic [1:0] evt_status;      // Sticky event bits
  logic [1:0] evt_mask;        // Event mask
  logic       level_above;     // Fill at or over threshold
  logic       addr_hit;        // Address comparator result
  logic [7:0] next_threshold;  // Lookup result
  logic       nine_evt;        // Qualifying address byte
  logic       level_rise;      // Threshold newly reached
  logic       bus_req;         // New request this cycle
  logic       wr_en;           // Write strobe, low lane
  logic [9:0] idx;             // Word index
  logic [7:0] next_rdata;      // Read mux result
  logic       clr_nb_flag;     // Software clear of nine-bit flag
  logic [1:0] clr_evt;         // Write-one-to-clear

  // Comparator for received address bytes
  ubx_addr_match #(.W(8)) u_match (
    .rx_byte    (RX_DATA),
    .slave_addr (slave_addr),
    .slave_mask (slave_mask),
    .bcast_addr (bcast_addr),
    .hit        (addr_hit)
  );

  // Threshold selection from bank and trigger code
  ubx_level_lut u_lut (
    .bank  (ext_ctrl[POS_LEVEL_BANK +: 2]),
    .code  (queue_trig),
    .level (next_threshold)
  );

  // Request decode; one access per handshake
  assign bus_req = WB_CYC_I && WB_STB_I && (bus_state == UBX_IDLE);
  assign idx     = WB_ADR_I[11:2];
  assign wr_en   = bus_req && WB_WE_I && WB_SEL_I[0];

  // Nine-bit qualification: ninth bit marks address, type picks match
  assign nine_evt = RX_VALID && RX_NINTH
                 && md_config[BIT_MULTIDROP_ENABLE]
                 && nb_ctrl[BIT_IRQ_ENABLE]
                 && (!nb_ctrl[BIT_IRQ_TYPE_SEL]
                     || addr_hit);

  assign level_above = (RX_FILL >= RX_THRESHOLD);
  assign level_rise  = level_above && !RX_TRIGGER_HIT;

  // Software clears: flag by writing 0, events by writing 1
  assign clr_nb_flag = wr_en && (idx == IDX_NB_FLAG)
                    && !WB_DAT_I[BIT_NB_FLAG];
  assign clr_evt = (wr_en && (idx == IDX_EVT_STATUS))
                 ? WB_DAT_I[1:0] : 2'h0;

  // Read mux; unmapped words and reserved bits read zero
  always_comb begin
    next_rdata = 8'h00;
    case (idx)
      IDX_MD_CONFIG:  next_rdata = md_config;
      IDX_SLAVE_ADDR: next_rdata = slave_addr;
      IDX_SLAVE_MASK: next_rdata = slave_mask;
      IDX_BCAST_ADDR: next_rdata = bcast_addr;
      IDX_NB_CTRL:    next_rdata = {6'h00, nb_ctrl};
      IDX_NB_FLAG:    next_rdata = {7'h00, nb_flag};
      IDX_EXT_CTRL:   next_rdata = ext_ctrl;
      IDX_QUEUE_CTRL: next_rdata = {queue_trig, 6'h00};
      IDX_EVT_STATUS: next_rdata = {6'h00, evt_status};
      IDX_EVT_MASK:   next_rdata = {6'h00, evt_mask};
      default:        next_rdata = 8'h00;
    endcase
  end

  // Bus handshake: ack one cycle after request, dropped next cycle
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      bus_state <= UBX_IDLE;
      WB_ACK_O  <= 1'b0;
      WB_DAT_O  <= 32'h0000_0000;
    end else if (CE) begin
      case (bus_state)
        UBX_IDLE: begin
          if (bus_req) begin
            bus_state <= UBX_ACK;
            WB_ACK_O  <= 1'b1;
            WB_DAT_O  <= {24'h00_0000, next_rdata};
          end
        end
        UBX_ACK: begin
          // Gap cycle keeps a held strobe from re-triggering
          bus_state <= UBX_IDLE;
          WB_ACK_O  <= 1'b0;
        end
        default: begin
          bus_state <= UBX_IDLE;
          WB_ACK_O  <= 1'b0;
        end
      endcase
    end
  end

  // Address configuration registers
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      md_config  <= RST_MD_CONFIG;
      slave_addr <= RST_SLAVE_ADDR;
      slave_mask <= RST_SLAVE_MASK;
      bcast_addr <= RST_BCAST_ADDR;
    end else if (CE && wr_en) begin
      case (idx)
        IDX_MD_CONFIG:  md_config  <= WB_DAT_I[7:0];
        IDX_SLAVE_ADDR: slave_addr <= WB_DAT_I[7:0];
        IDX_SLAVE_MASK: slave_mask <= WB_DAT_I[7:0];
        IDX_BCAST_ADDR: bcast_addr <= WB_DAT_I[7:0];
        default: ;
      endcase
    end
  end

  // Interrupt control; starts with matched type, output disabled
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      nb_ctrl <= RST_NB_CTRL;
    end else if (CE && wr_en && (idx == IDX_NB_CTRL)) begin
      nb_ctrl <= WB_DAT_I[1:0];
    end
  end

  // Nine-bit flag; a new event beats a same-cycle clear
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      nb_flag <= 1'b0;
    end else if (CE) begin
      if (nine_evt) begin
        nb_flag <= 1'b1;
      end else if (clr_nb_flag) begin
        nb_flag <= 1'b0;
      end
    end
  end

  // Nine-bit interrupt pin, registered; enable gates it one cycle later
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      NINE_BIT_IRQ <= 1'b0;
    end else if (CE) begin
      NINE_BIT_IRQ <= nb_flag && nb_ctrl[BIT_IRQ_ENABLE];
    end
  end

  // Extension register; reserved bits dropped, so they read zero
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ext_ctrl <= RST_EXT_CTRL;
    end else if (CE && wr_en && (idx == IDX_EXT_CTRL)) begin
      ext_ctrl <= WB_DAT_I[7:0] & EXT_WRITE_MASK;
    end
  end

  // Queue control trigger code
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      queue_trig <= RST_QUEUE_TRIG;
    end else if (CE && wr_en && (idx == IDX_QUEUE_CTRL)) begin
      queue_trig <= WB_DAT_I[POS_QUEUE_TRIG +: 2];
    end
  end

  // Configuration outputs, registered one cycle after the source
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      MULTIDROP_ENABLE  <= 1'b0;
      DEEP_QUEUE_ENABLE <= 1'b0;
      PORT_SWAP_BYPASS  <= 1'b0;
      QUEUE_DEPTH       <= DEPTH_STD;
      RX_THRESHOLD      <= LEVEL_TABLE[0];
    end else if (CE) begin
      MULTIDROP_ENABLE  <= md_config[BIT_MULTIDROP_ENABLE];
      DEEP_QUEUE_ENABLE <= ext_ctrl[BIT_DEEP_QUEUE];
      PORT_SWAP_BYPASS  <= ext_ctrl[BIT_PORT_SWAP];
      // Depth applies to both directions
      QUEUE_DEPTH  <= ext_ctrl[BIT_DEEP_QUEUE]
                    ? DEPTH_DEEP : DEPTH_STD;
      RX_THRESHOLD <= next_threshold;
    end
  end

  // Threshold comparison against live fill
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      RX_TRIGGER_HIT <= 1'b0;
    end else if (CE) begin
      RX_TRIGGER_HIT <= level_above;
    end
  end

  // Sticky event bits; set wins over write-one-to-clear
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      evt_status <= 2'h0;
    end else if (CE) begin
      evt_status[EVT_NINE_BIT] <= nine_evt
        || (evt_status[EVT_NINE_BIT] && !clr_evt[EVT_NINE_BIT]);
      evt_status[EVT_RX_LEVEL] <= level_rise
        || (evt_status[EVT_RX_LEVEL] && !clr_evt[EVT_RX_LEVEL]);
    end
  end

  // Event mask
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      evt_mask <= RST_EVT_MASK;
    end else if (CE && wr_en && (idx == IDX_EVT_MASK)) begin
      evt_mask <= WB_DAT_I[1:0];
    end
  end

  // Combined level interrupt
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(evt_status & evt_mask);
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  // Write into a register, then two frozen-free cycles to propagate
  sequence s_ext_write;
    CE && wr_en && (idx == IDX_EXT_CTRL);
  endsequence
  sequence s_settle;
    CE ##1 CE;
  endsequence

  a_any_addr_irq: assert property (
    CE && RX_VALID && RX_NINTH && md_config[0] && nb_ctrl == 2'h1
    |=> nb_flag)
    else $error("any address byte did not set flag");

  a_match_only_irq: assert property (
    CE && !nb_flag && RX_VALID && nb_ctrl == 2'h3 && !addr_hit
    |=> !nb_flag)
    else $error("mismatched address set flag");

  a_irq_gated: assert property (
    CE && !nb_ctrl[0] |=> !NINE_BIT_IRQ)
    else $error("nine-bit irq while disabled");

  a_flag_reads: assert property (
    CE && bus_req && !WB_WE_I && idx == IDX_NB_FLAG
    |=> WB_ACK_O && WB_DAT_O == {31'h0, $past(nb_flag)})
    else $error("flag read mismatch");

  a_level_table: assert property (
    s_ext_write ##0 (WB_DAT_I[7:6] == 2'h0 && queue_trig == 2'h3)
    ##1 s_settle |-> RX_THRESHOLD == 8'h0e)
    else $error("bank 00 code 11 not 14");

  a_deep_depth: assert property (
    s_ext_write ##0 WB_DAT_I[0] ##1 s_settle
    |-> QUEUE_DEPTH == 8'h80 && DEEP_QUEUE_ENABLE)
    else $error("deep queue not applied");

  a_reserved_zero: assert property (
    (ext_ctrl & ~EXT_WRITE_MASK) == 8'h00)
    else $error("reserved extension bits set");

  a_ctrl_reset: assert property (
    $rose(RESETN) |-> nb_ctrl == 2'h2)
    else $error("control reset value wrong");

  a_data_no_flag: assert property (
    CE && !nb_flag && RX_VALID && !RX_NINTH |=> !nb_flag)
    else $error("data byte set nine-bit flag");

  a_flag_sticky: assert property (
    nb_flag && !(CE && clr_nb_flag) |=> nb_flag)
    else $error("flag dropped without clear");

  a_irq_level: assert property (
    CE && (evt_status & evt_mask) != 2'h0 |=> IRQ)
    else $error("unmasked event without irq");

  // Address byte taken while the enable is high
  sequence s_addr_byte;
    CE && RX_VALID && RX_NINTH;
  endsequence

  a_match_sets: assert property (
    s_addr_byte ##0 (md_config[0] && nb_ctrl == 2'h3 && addr_hit)
    |=> nb_flag)
    else $error("matching address did not set flag");

  a_mode_gate: assert property (
    s_addr_byte ##0 (!nb_flag && !md_config[0]) |=> !nb_flag)
    else $error("flag set outside nine-bit mode");

  a_irq_drives: assert property (
    CE && nb_flag && nb_ctrl[0] |=> NINE_BIT_IRQ)
    else $error("nine-bit irq missing while enabled");

  a_flag_clears: assert property (
    CE && clr_nb_flag && !nine_evt |=> !nb_flag)
    else $error("flag not cleared by zero write");

  a_ack_pulse: assert property (
    CE && WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held past one cycle");

  // Low enable must freeze flags and handshake alike
  a_freeze_hold: assert property (
    !CE |=> $stable(nb_flag) && $stable(evt_status) && $stable(WB_ACK_O))
    else $error("state moved while enable low");

endmodule // ubx_top

// *** ubx_pkg.sv ***
// Constants and types shared by the nine-bit interrupt and queue extension
package ubx_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_MD_CONFIG   = 10'h0f2;
  localparam logic [9:0] IDX_SLAVE_ADDR  = 10'h0f3;
  localparam logic [9:0] IDX_SLAVE_MASK  = 10'h0f4;
  localparam logic [9:0] IDX_BCAST_ADDR  = 10'h0f5;
  localparam logic [9:0] IDX_NB_CTRL     = 10'h0f6;
  localparam logic [9:0] IDX_NB_FLAG     = 10'h0f7;
  localparam logic [9:0] IDX_EXT_CTRL    = 10'h0f8;
  localparam logic [9:0] IDX_QUEUE_CTRL  = 10'h0f9;
  localparam logic [9:0] IDX_EVT_STATUS  = 10'h0fa;
  localparam logic [9:0] IDX_EVT_MASK    = 10'h0fb;

  // Reset values
  localparam logic [7:0] RST_MD_CONFIG   = 8'h00;
  localparam logic [7:0] RST_SLAVE_ADDR  = 8'h00;
  localparam logic [7:0] RST_SLAVE_MASK  = 8'hff;
  localparam logic [7:0] RST_BCAST_ADDR  = 8'hff;
  localparam logic [1:0] RST_NB_CTRL     = 2'h2;
  localparam logic [7:0] RST_EXT_CTRL    = 8'h00;
  localparam logic [1:0] RST_QUEUE_TRIG  = 2'h0;
  localparam logic [1:0] RST_EVT_MASK    = 2'h0;

  // Field positions
  localparam int BIT_MULTIDROP_ENABLE = 0;
  localparam int BIT_IRQ_ENABLE       = 0;
  localparam int BIT_IRQ_TYPE_SEL     = 1;
  localparam int BIT_NB_FLAG          = 0;
  localparam int BIT_DEEP_QUEUE       = 0;
  localparam int BIT_PORT_SWAP        = 4;
  localparam int POS_LEVEL_BANK       = 6;
  localparam int POS_QUEUE_TRIG       = 6;
  localparam int EVT_NINE_BIT         = 0;
  localparam int EVT_RX_LEVEL         = 1;

  // Writable bits of the extension register; bits 5 and 3-1 reserved
  localparam logic [7:0] EXT_WRITE_MASK = 8'hd1;

  // Queue depths
  localparam logic [7:0] DEPTH_STD  = 8'h10;
  localparam logic [7:0] DEPTH_DEEP = 8'h80;

  // Receive thresholds in bytes, bank-major then trigger code
  localparam logic [7:0] LEVEL_TABLE [16] = '{
    8'h01, 8'h04, 8'h08, 8'h0e,
    8'h10, 8'h20, 8'h30, 8'h40,
    8'h50, 8'h58, 8'h60, 8'h68,
    8'h70, 8'h74, 8'h78, 8'h7c };

  // Bus slave states
  typedef enum logic [1:0] {
    UBX_IDLE = 2'b01,
    UBX_ACK  = 2'b10
  } ubx_bus_t;

endpackage

// *** ubx_addr_match.sv ***
// Masked slave and broadcast address comparison for received bytes
`timescale 1ns/1ps
module ubx_addr_match #(
  parameter int W = 8
) (
  // Received byte
  input  wire logic [W-1:0] rx_byte,
  // Address configuration
  input  wire logic [W-1:0] slave_addr,
  input  wire logic [W-1:0] slave_mask,
  input  wire logic [W-1:0] bcast_addr,
  // Result
  output      logic         hit
);
  // Only mask ones take part; broadcast always compares whole byte
  assign hit = (((rx_byte ^ slave_addr) & slave_mask) == '0)
             || (rx_byte == bcast_addr);
endmodule // ubx_addr_match

// *** ubx_level_lut.sv ***
// Receive threshold lookup from bank and trigger code
`timescale 1ns/1ps
module ubx_level_lut
  import ubx_pkg::*;
(
  // Selectors
  input  wire logic [1:0] bank,
  input  wire logic [1:0] code,
  // Threshold in bytes
  output      logic [7:0] level
);
  // Table indexed bank-major so bank 00 keeps legacy levels
  assign level = LEVEL_TABLE[{bank, code}];
endmodule // ubx_level_lut

// *** ubx_node.sv ***
// Remote multidrop node model feeding received bytes to the block
`timescale 1ns/1ps
module ubx_node (
  // Clock
  input  wire logic       clk,
  // Received byte stream
  output      logic       rx_valid,
  output      logic [7:0] rx_data,
  output      logic       rx_ninth,
  output      logic [7:0] rx_fill
);
  // Quiet line at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_ninth = 1'b0;
    rx_fill = 8'h00;
  end

  // One byte per call after gap idle cycles; ninth bit marks an address
  task automatic send(input logic [7:0] d, input logic a, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_ninth <= a;
    @(posedge clk);
    rx_valid <= 1'b0;
    // Inverted leftovers so a stale byte never looks valid
    rx_data <= ~d;
    rx_ninth <= ~a;
  endtask

  // Fill level of the receive queue
  task automatic level(input logic [7:0] f);
    @(posedge clk);
    rx_fill <= f;
  endtask
endmodule // ubx_node

// *** tb.sv ***
// Self-checking bench for the nine-bit interrupt and queue extension
`timescale 1ns/1ps
module tb;
  import ubx_pkg::*;
  logic        clk = 1'b0;    // System clock
  logic        rst_n = 1'b0;  // Active-low reset
  logic        cyc = 1'b0;    // Bus request
  logic        we = 1'b0;     // Write direction
  logic [11:0] adr = 12'h000; // Byte address
  logic [31:0] wdat = 32'h0;  // Write data
  logic [31:0] rdat;          // Read data
  logic        ack;           // Bus answer
  logic        ce = 1'b1;     // Clock enable
  logic        rxv, rxn, dq, swp, hit, nb_irq, irq, md;
  logic [7:0]  rxd, rxf, depth, thr;
  logic [31:0] r;             // Last read value
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  // Expected thresholds, bank-major
  logic [7:0]  lv [16] = '{8'h01, 8'h04, 8'h08, 8'h0e, 8'h10, 8'h20,
    8'h30, 8'h40, 8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'h74, 8'h78, 8'h7c};

  always #10 clk = ~clk;

  ubx_top dut (.CLOCK(clk), .RESETN(rst_n), .CE(ce),
    .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .RX_VALID(rxv), .RX_DATA(rxd), .RX_NINTH(rxn), .RX_FILL(rxf),
    .MULTIDROP_ENABLE(md), .DEEP_QUEUE_ENABLE(dq), .PORT_SWAP_BYPASS(swp),
    .QUEUE_DEPTH(depth), .RX_THRESHOLD(thr), .RX_TRIGGER_HIT(hit),
    .NINE_BIT_IRQ(nb_irq), .IRQ(irq));

  ubx_node n (.clk(clk), .rx_valid(rxv), .rx_data(rxd), .rx_ninth(rxn),
    .rx_fill(rxf));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; holds the request until ack is sampled
  task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] i, input logic [7:0] exp);
    wb(1'b0, i, 8'h00);
    chk(r, {24'h0, exp});
  endtask

  // Outputs follow their source within two cycles
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    rd(IDX_NB_CTRL, 8'h02);
    rd(IDX_NB_FLAG, 8'h00);
    rd(IDX_EXT_CTRL, 8'h00);
    chk(depth, 8'h10);
    chk(thr, 8'h01);
    chk({md, dq, swp, nb_irq, irq}, 5'h00);
  endtask

  // Every bank and code, with the fill just below and at the level
  task automatic t_levels;
    for (int b = 0; b < 4; b++) begin
      wb(1'b1, IDX_EXT_CTRL, 8'(b << 6));
      for (int c = 0; c < 4; c++) begin
        wb(1'b1, IDX_QUEUE_CTRL, 8'(c << 6));
        n.level(lv[b*4+c] - 8'h01);
        settle();
        chk(thr, lv[b*4+c]);
        chk(hit, 1'b0);
        n.level(lv[b*4+c]);
        settle();
        chk(hit, 1'b1);
      end
    end
  endtask

  task automatic t_deep;
    wb(1'b1, IDX_EXT_CTRL, 8'h11);
    settle();
    chk({swp, dq, depth}, {2'b11, 8'h80});
    rd(IDX_EXT_CTRL, 8'h11);
    wb(1'b1, IDX_EXT_CTRL, 8'h00);
    settle();
    chk({dq, depth}, {1'b0, 8'h10});
  endtask

  // Any address byte interrupts; data bytes never do
  task automatic t_any;
    wb(1'b1, IDX_NB_CTRL, 8'h01);
    n.send(8'h34, 1'b1, 0);
    settle();
    rd(IDX_NB_FLAG, 8'h00);
    chk(md, 1'b0);
    wb(1'b1, IDX_MD_CONFIG, 8'h01);
    wb(1'b1, IDX_SLAVE_ADDR, 8'h12);
    chk(md, 1'b1);
    n.send(8'h34, 1'b0, 0);
    settle();
    rd(IDX_NB_FLAG, 8'h00);
    n.send(8'h34, 1'b1, 2);
    settle();
    chk(nb_irq, 1'b1);
    rd(IDX_NB_FLAG, 8'h01);
    wb(1'b1, IDX_NB_FLAG, 8'h01);
    rd(IDX_NB_FLAG, 8'h01);
    wb(1'b1, IDX_NB_FLAG, 8'h00);
    rd(IDX_NB_FLAG, 8'h00);
  endtask

  // Matching only, then the enable gate on a standing flag
  task automatic t_match;
    wb(1'b1, IDX_NB_CTRL, 8'h03);
    n.send(8'h34, 1'b1, 0);
    settle();
    rd(IDX_NB_FLAG, 8'h00);
    n.send(8'h12, 1'b1, 0);
    settle();
    rd(IDX_NB_FLAG, 8'h01);
    wb(1'b1, IDX_NB_CTRL, 8'h02);
    settle();
    chk(nb_irq, 1'b0);
    wb(1'b1, IDX_NB_CTRL, 8'h03);
    settle();
    chk(nb_irq, 1'b1);
    wb(1'b1, IDX_NB_FLAG, 8'h00);
    n.send(8'hff, 1'b1, 0);
    settle();
    rd(IDX_NB_FLAG, 8'h01);
    wb(1'b1, IDX_NB_FLAG, 8'h00);
    wb(1'b1, IDX_SLAVE_MASK, 8'hf0);
    n.send(8'h22, 1'b1, 0);
    settle();
    rd(IDX_NB_FLAG, 8'h00);
    n.send(8'h1a, 1'b1, 0);
    settle();
    rd(IDX_NB_FLAG, 8'h01);
  endtask

  // Sticky status, mask and clear by writing ones; unmapped place
  task automatic t_event;
    wb(1'b1, IDX_EVT_STATUS, 8'h03);
    wb(1'b1, IDX_EVT_MASK, 8'h01);
    settle();
    chk(irq, 1'b0);
    n.send(8'h12, 1'b1, 1);
    settle();
    chk(irq, 1'b1);
    wb(1'b1, IDX_EVT_STATUS, 8'h01);
    settle();
    chk(irq, 1'b0);
    wb(1'b1, IDX_EVT_MASK, 8'h02);
    n.level(8'h00);
    settle();
    chk(irq, 1'b0);
    n.level(8'h0e);
    settle();
    chk(irq, 1'b1);
    wb(1'b1, IDX_EVT_STATUS, 8'h02);
    settle();
    chk(irq, 1'b0);
    wb(1'b1, 10'h100, 8'hff);
    rd(10'h100, 8'h00);
  endtask

  // Low enable: an address byte is ignored, a fill change waits for the enable
  task automatic t_freeze;
    wb(1'b1, IDX_NB_FLAG, 8'h00);
    n.level(8'h00);
    settle();
    ce <= 1'b0;
    n.level(8'h7c);
    n.send(8'h12, 1'b1, 0);
    settle();
    chk(hit, 1'b0);
    ce <= 1'b1;
    settle();
    chk(hit, 1'b1);
    rd(IDX_NB_FLAG, 8'h00);
  endtask

  // Reset again mid-run; registers and outputs return to defaults
  task automatic t_rerun;
    n.level(8'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    rd(IDX_EVT_STATUS, 8'h00);
    chk(hit, 1'b0);
  endtask

  task automatic final_report;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_levels();
    t_deep();
    t_any();
    t_match();
    t_event();
    t_freeze();
    t_rerun();
    final_report();
  end
endmodule // tb
